/* core/dpsw_host.sv */
// host controller driving one port of the dual-port sram and its semaphores
`timescale 1ns/1ps
`default_nettype none
module dpsw_host
	import dpsw_pkg::*;
#(
	parameter bit OE_LOW_DURING_WRITE = 1'b0
) (
	input wire logic i_clock, // 125 MHz clock
	input wire logic i_rst, // async reset, high
	input wire logic i_req_valid, // request strobe
	input wire dpsw_pkg::dpsw_req_type i_req, // request fields
	output logic o_req_ready, // idle, may take request
	output logic o_done, // one-cycle completion pulse
	output logic [dpsw_pkg::DATA_WIDTH-1:0] o_rdata, // read data, registered
	output logic o_sem_granted, // semaphore readback flag is zero
	output logic o_sem_mismatch, // semaphore bits disagree
	output dpsw_pkg::dpsw_ctrl_type o_ctrl, // control pins, all active low
	output logic [dpsw_pkg::ADDR_WIDTH-1:0] o_addr, // address pins
	output logic [dpsw_pkg::DATA_WIDTH-1:0] o_data_out, // data pins out
	output logic o_data_oe, // high while host drives data
	input wire logic [dpsw_pkg::DATA_WIDTH-1:0] i_data_in // data pins in
);
	import dpsw_pkg::*;
	// strobe split when outputs stay enabled: wait for turn-off, then data setup
	localparam int WR_Z_CYC = cyc_up(T_WRITE_Z_PS);
	localparam int DATA_SETUP_CYC = cyc_up(T_DATA_SETUP_PS);
	localparam int OE_DATA_CYC = (WR_PULSE_CYC > WR_Z_CYC + DATA_SETUP_CYC) ?
		WR_PULSE_CYC - WR_Z_CYC : DATA_SETUP_CYC;
	typedef enum {
		ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_SEM_GAP, ST_READ, ST_TURN
	} dpsw_state_type;
	//----------------------------------------
	// state
	//----------------------------------------
	dpsw_state_type state_reg, state_next;
	dpsw_req_type req_reg, req_next;
	dpsw_ctrl_type ctrl_reg, ctrl_next;
	logic oe_reg, oe_next;
	logic done_reg, done_next;
	logic [DATA_WIDTH-1:0] rdata_reg, rdata_next;
	logic granted_reg, granted_next;
	logic mismatch_reg, mismatch_next;
	logic [DATA_WIDTH-1:0] sync1_reg, sync2_reg;
	logic load;
	logic [CNT_WIDTH-1:0] load_value;
	logic timer_done;
	// refuse timings that the phase timer cannot hold
	if (WR_PULSE_CYC >= (1 << CNT_WIDTH) || READ_CYC + 2 >= (1 << CNT_WIDTH) ||
		OE_DATA_CYC >= (1 << CNT_WIDTH) || WR_Z_CYC >= (1 << CNT_WIDTH)) begin : g_timer_check
		$error("timer too narrow");
	end
	dpsw_counter #(.WIDTH(CNT_WIDTH)) u_timer (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_load(load),
		.i_value(load_value),
		.o_done(timer_done)
	);
	// two-flop synchroniser on data pins
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= i_data_in;
			sync2_reg <= sync1_reg;
		end
	end
	function automatic logic is_write(input dpsw_cmd_type c);
		return (c == DPSW_CMD_RAM_WRITE) || (c == DPSW_CMD_SEM_WRITE);
	endfunction : is_write
	function automatic logic is_sem(input dpsw_cmd_type c);
		return (c == DPSW_CMD_SEM_WRITE) || (c == DPSW_CMD_SEM_READ);
	endfunction : is_sem
	//----------------------------------------
	// sequencer
	//----------------------------------------
	always_comb begin
		state_next = state_reg;
		req_next = req_reg;
		ctrl_next = ctrl_reg;
		oe_next = oe_reg;
		done_next = 1'b0;
		rdata_next = rdata_reg;
		granted_next = granted_reg;
		mismatch_next = mismatch_reg;
		load = 1'b0;
		load_value = '0;
		case (state_reg)
			ST_IDLE: begin
				ctrl_next = CTRL_IDLE;
				oe_next = 1'b0;
				if (i_req_valid) begin
					req_next = i_req;
					state_next = ST_SETUP;
					load = 1'b1;
					load_value = CNT_WIDTH'(ADDR_SETUP_CYC);
					// select exactly one space; semaphore keeps cs and byte selects high
					ctrl_next.chip_select_n = is_sem(i_req.cmd);
					ctrl_next.semaphore_select_n = !is_sem(i_req.cmd);
					ctrl_next.output_enable_n = is_write(i_req.cmd) ? !OE_LOW_DURING_WRITE : 1'b1;
					ctrl_next.upper_byte_select_n = is_sem(i_req.cmd) ? 1'b1 : !i_req.byte_en[1];
					ctrl_next.lower_byte_select_n = is_sem(i_req.cmd) ? 1'b1 : !i_req.byte_en[0];
				end
			end
			ST_SETUP: begin
				if (timer_done) begin
					load = 1'b1;
					if (is_write(req_reg.cmd)) begin
						// strobe falls with select already low, device off only when OE_LOW_DURING_WRITE is clear
						ctrl_next.write_n = 1'b0;
						state_next = ST_STROBE;
						// with outputs enabled, first wait for them to turn off
						load_value = (ctrl_reg.output_enable_n == 1'b0) ?
							CNT_WIDTH'(WR_Z_CYC) : CNT_WIDTH'(WR_PULSE_CYC);
					end else begin
						ctrl_next.output_enable_n = 1'b0;
						state_next = ST_READ;
						load_value = CNT_WIDTH'(is_sem(req_reg.cmd) ? SEM_READ_CYC : READ_CYC) +
							CNT_WIDTH'(2); // allow for input synchroniser
					end
				end
			end
			ST_STROBE: begin
				if (timer_done) begin
					load = 1'b1;
					if (!ctrl_reg.output_enable_n && !oe_reg) begin
						// device outputs now off, drive data for its setup time
						oe_next = 1'b1;
						load_value = CNT_WIDTH'(OE_DATA_CYC);
					end else begin
						ctrl_next.write_n = 1'b1;
						// enabled outputs drive again at once, so let go now
						oe_next = ctrl_reg.output_enable_n;
						state_next = ST_RECOVER;
						load_value = CNT_WIDTH'(RECOVERY_CYC);
					end
				end else if (ctrl_reg.output_enable_n) begin
					oe_next = 1'b1; // outputs disabled, drive once strobe is low
				end
			end
			ST_RECOVER: begin
				if (timer_done) begin
					oe_next = 1'b0; // release bus before any read
					ctrl_next = CTRL_IDLE;
					if (req_reg.cmd == DPSW_CMD_SEM_WRITE) begin
						// readback of the flag just written
						ctrl_next.semaphore_select_n = 1'b1;
						state_next = ST_SEM_GAP;
						load = 1'b1;
						load_value = CNT_WIDTH'(SEM_GAP_CYC);
					end else begin
						state_next = ST_TURN;
						load = 1'b1;
						load_value = CNT_WIDTH'(TURNAROUND_CYC);
					end
				end
			end
			ST_SEM_GAP: begin
				if (timer_done) begin
					req_next.cmd = DPSW_CMD_SEM_READ;
					ctrl_next.semaphore_select_n = 1'b0;
					ctrl_next.output_enable_n = 1'b0;
					state_next = ST_READ;
					load = 1'b1;
					load_value = CNT_WIDTH'(SEM_READ_CYC) + CNT_WIDTH'(2);
				end
			end
			ST_READ: begin
				if (timer_done) begin
					rdata_next = sync2_reg;
					if (is_sem(req_reg.cmd)) begin
						// every bit carries the flag; zero means we won
						granted_next = !sync2_reg[0];
						mismatch_next = (sync2_reg != {DATA_WIDTH{sync2_reg[0]}});
					end
					ctrl_next = CTRL_IDLE;
					state_next = ST_TURN;
					load = 1'b1;
					load_value = CNT_WIDTH'(TURNAROUND_CYC);
				end
			end
			ST_TURN: begin
				if (timer_done) begin
					done_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
				ctrl_next = CTRL_IDLE;
				oe_next = 1'b0;
			end
		endcase
	end
	// register sequencer state
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
			req_reg <= '0;
			ctrl_reg <= CTRL_IDLE;
			oe_reg <= 1'b0;
			done_reg <= 1'b0;
			rdata_reg <= '0;
			granted_reg <= 1'b0;
			mismatch_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			req_reg <= req_next;
			ctrl_reg <= ctrl_next;
			oe_reg <= oe_next;
			done_reg <= done_next;
			rdata_reg <= rdata_next;
			granted_reg <= granted_next;
			mismatch_reg <= mismatch_next;
		end
	end
	// pin outputs
	assign o_ctrl = ctrl_reg;
	assign o_addr = is_sem(req_reg.cmd) ?
		{{(ADDR_WIDTH-SEM_ADDR_WIDTH){1'b0}}, req_reg.addr[SEM_ADDR_WIDTH-1:0]} : req_reg.addr;
	assign o_data_out = (req_reg.cmd == DPSW_CMD_SEM_WRITE) ?
		{{(DATA_WIDTH-1){1'b0}}, req_reg.wdata[0]} : req_reg.wdata;
	assign o_data_oe = oe_reg;
	assign o_req_ready = (state_reg == ST_IDLE);
	assign o_done = done_reg;
	assign o_rdata = rdata_reg;
	assign o_sem_granted = granted_reg;
	assign o_sem_mismatch = mismatch_reg;
endmodule : dpsw_host
`default_nettype wire

/* core/dpsw_pkg.sv */
// package of constants and carriers for the dual-port sram write and semaphore host controller
// Contract
// - ram needs cs low, semaphore needs sem low
// - hold we high while address changes
// - strobe covers output turn-off plus setup
// - never drive data while device drives
// - semaphore write and readback keep cs high
package dpsw_pkg;
	//----------------------------------------
	// widths
	//----------------------------------------
	localparam int ADDR_WIDTH = 14;
	localparam int DATA_WIDTH = 16;
	localparam int SEM_ADDR_WIDTH = 3;
	localparam int CLOCK_MHZ = 125;
	localparam int CLOCK_PERIOD_PS = 1000000 / CLOCK_MHZ;
	//----------------------------------------
	// timing in picoseconds (slowest grade minima)
	//----------------------------------------
	localparam int T_WRITE_PULSE_PS = 40000;
	localparam int T_ADDR_SETUP_PS = 0;
	localparam int T_DATA_SETUP_PS = 30000;
	localparam int T_WRITE_Z_PS = 25000;
	localparam int T_WRITE_RECOVERY_PS = 0;
	localparam int T_OUT_HIGHZ_PS = 25000;
	localparam int T_SEM_WR_TO_RD_PS = 5000;
	localparam int T_SEM_ACCESS_PS = 55000;
	localparam int T_READ_ACCESS_PS = 55000;
	function automatic int cyc_up(input int ps);
		int c;
		c = (ps + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up
	localparam int WR_PULSE_CYC = cyc_up(T_WRITE_PULSE_PS);
	localparam int WR_PULSE_OE_CYC = cyc_up(T_WRITE_Z_PS + T_DATA_SETUP_PS);
	localparam int ADDR_SETUP_CYC = cyc_up(T_ADDR_SETUP_PS);
	localparam int RECOVERY_CYC = cyc_up(T_WRITE_RECOVERY_PS);
	localparam int TURNAROUND_CYC = cyc_up(T_OUT_HIGHZ_PS);
	localparam int SEM_GAP_CYC = cyc_up(T_SEM_WR_TO_RD_PS);
	localparam int SEM_READ_CYC = cyc_up(T_SEM_ACCESS_PS);
	localparam int READ_CYC = cyc_up(T_READ_ACCESS_PS);
	localparam int CNT_WIDTH = 8;
	//----------------------------------------
	// command encoding
	//----------------------------------------
	typedef enum logic [1:0] {
		DPSW_CMD_RAM_WRITE,
		DPSW_CMD_RAM_READ,
		DPSW_CMD_SEM_WRITE,
		DPSW_CMD_SEM_READ
	} dpsw_cmd_type;
	typedef struct packed {
		dpsw_cmd_type cmd;
		logic [ADDR_WIDTH-1:0] addr;
		logic [DATA_WIDTH-1:0] wdata;
		logic [1:0] byte_en; // bit1 upper, bit0 lower
	} dpsw_req_type;
	typedef struct packed {
		logic chip_select_n;
		logic semaphore_select_n;
		logic write_n;
		logic output_enable_n;
		logic upper_byte_select_n;
		logic lower_byte_select_n;
	} dpsw_ctrl_type;
	localparam dpsw_ctrl_type CTRL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : dpsw_pkg

/* core/dpsw_counter.sv */
// down-counter timing one phase of a pin cycle
`timescale 1ns/1ps
`default_nettype none
module dpsw_counter #(
	parameter int WIDTH = 8
) (
	input wire logic i_clock, // system clock
	input wire logic i_rst, // async reset, high
	input wire logic i_load, // load pulse
	input wire logic [WIDTH-1:0] i_value, // cycles to count
	output logic o_done // count expired
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	// refuse a width that cannot hold a count and its expiry
	if (WIDTH < 2) begin : g_width_check
		$error("counter width too small");
	end
	// next count
	always_comb begin
		count_next = count_reg;
		if (i_load) begin
			count_next = i_value;
		end else if (count_reg != '0) begin
			count_next = count_reg - 1'b1;
		end
	end
	// register
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end
	// expiry reads the register only, so a load decided from it forms no loop
	assign o_done = (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1});
endmodule : dpsw_counter
`default_nettype wire

/* tb/dpsw_host_checker.sv */
// pin protocol assertions for the sram host controller
`timescale 1ns/1ps
`default_nettype none
module dpsw_host_checker (
	input wire logic i_clock, // clock
	input wire logic i_rst, // async reset
	input wire logic o_done, // completion pulse
	input wire dpsw_pkg::dpsw_ctrl_type o_ctrl, // control pins
	input wire logic [dpsw_pkg::ADDR_WIDTH-1:0] o_addr, // address pins
	input wire logic o_data_oe // host drives data
);
	import dpsw_pkg::*;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	//----------------------------------------
	// select, address and strobe relations
	//----------------------------------------
	chk_one_select: assert property (o_ctrl.chip_select_n || o_ctrl.semaphore_select_n)
		else $error("ram and semaphore selected together");
	chk_sel_steady: assert property ((!o_ctrl.write_n && !$past(o_ctrl.write_n))
		|-> $stable({o_ctrl.chip_select_n, o_ctrl.semaphore_select_n}))
		else $error("select moved inside write");
	chk_addr_quiet: assert property ($changed(o_addr) |-> (o_ctrl.write_n
		|| o_ctrl.chip_select_n || (o_ctrl.upper_byte_select_n && o_ctrl.lower_byte_select_n)))
		else $error("address moved while writing");
	chk_pulse_long: assert property ($fell(o_ctrl.write_n) |-> !o_ctrl.write_n [*5])
		else $error("write strobe too short");
	chk_no_clash: assert property (o_data_oe |-> (!o_ctrl.write_n
		|| o_ctrl.output_enable_n || (o_ctrl.chip_select_n && o_ctrl.semaphore_select_n)))
		else $error("host drives while device may drive");
	chk_sem_lanes: assert property (!o_ctrl.semaphore_select_n |-> (o_ctrl.chip_select_n
		|| (o_ctrl.upper_byte_select_n && o_ctrl.lower_byte_select_n)))
		else $error("semaphore access with ram lanes open");
	// main scenarios reached
	cover property ($fell(o_ctrl.write_n) && !o_ctrl.chip_select_n);
	cover property (!o_ctrl.semaphore_select_n && !o_ctrl.write_n);
	cover property (o_done);
endmodule : dpsw_host_checker
`default_nettype wire

/* tb/dpsw_sram_model.sv */
// behavioural model of one sram port with its semaphore flags
`timescale 1ns/1ps
`default_nettype none
module dpsw_sram_model
	import dpsw_pkg::*;
#(
	parameter int ACCESS_NS = 20
) (
	input wire dpsw_pkg::dpsw_ctrl_type i_ctrl, // control pins
	input wire logic [dpsw_pkg::ADDR_WIDTH-1:0] i_addr, // address pins
	input wire logic [dpsw_pkg::DATA_WIDTH-1:0] i_host_data, // host data
	input wire logic i_host_oe, // host drives data
	input wire logic [7:0] i_other_owns, // flags held by far port
	output logic [dpsw_pkg::DATA_WIDTH-1:0] o_pin, // resolved data pins
	output logic o_clash // sticky contention flag
);
	logic [DATA_WIDTH-1:0] mem [2**ADDR_WIDTH];
	logic [7:0] mine = 8'h00;
	logic [DATA_WIDTH-1:0] last = '0;
	wire logic [DATA_WIDTH-1:0] dev_q;
	wire logic ram_wr = !i_ctrl.chip_select_n && !i_ctrl.write_n;
	wire logic sem_wr = !i_ctrl.semaphore_select_n && !i_ctrl.write_n;
	wire logic sel = !i_ctrl.chip_select_n || !i_ctrl.semaphore_select_n;
	// device drives only when selected, enabled and not in a write
	wire logic dev_oe = sel && !i_ctrl.output_enable_n && i_ctrl.write_n;
	assign #(ACCESS_NS) dev_q = i_ctrl.chip_select_n ? {16{~mine[i_addr[2:0]]}} : mem[i_addr];
	// released pins show the inverse of the last driven value
	assign o_pin = i_host_oe ? i_host_data : dev_oe ? dev_q : ~last;
	always @(o_pin) if (i_host_oe || dev_oe) last = o_pin;
	initial o_clash = 1'b0;
	always @* if (i_host_oe && dev_oe) o_clash = 1'b1;
	// writes land as the overlap ends
	always @(negedge ram_wr) begin
		if (!i_ctrl.upper_byte_select_n) mem[i_addr][15:8] = o_pin[15:8];
		if (!i_ctrl.lower_byte_select_n) mem[i_addr][7:0] = o_pin[7:0];
	end
	always @(negedge sem_wr) begin
		if (o_pin[0]) mine[i_addr[2:0]] = 1'b0;
		else if (!i_other_owns[i_addr[2:0]]) mine[i_addr[2:0]] = 1'b1;
	end
endmodule : dpsw_sram_model
`default_nettype wire

/* tb/tb_dpsw_host.sv */
// self-checking bench for the sram host controller
`timescale 1ns/1ps
`default_nettype none
module tb_dpsw_host;
	import dpsw_pkg::*;
	localparam logic [7:0] OTHER = 8'hAA;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic i_req_valid = 1'b0;
	dpsw_req_type i_req = '0;
	logic o_req_ready, o_done, o_sem_granted, o_sem_mismatch, o_data_oe, clash;
	logic [DATA_WIDTH-1:0] o_rdata, o_data_out, pin;
	logic [ADDR_WIDTH-1:0] o_addr;
	dpsw_ctrl_type o_ctrl;
	int err_count = 0;
	int n_checks = 0;
	int seed = 32'hd48a;
	int ref_mem [int];
	bit sem_own [8];
	always #4 i_clock = ~i_clock;
	dpsw_host dpsw_host_inst (.i_clock(i_clock), .i_rst(i_rst), .i_req_valid(i_req_valid),
		.i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata),
		.o_sem_granted(o_sem_granted), .o_sem_mismatch(o_sem_mismatch), .o_ctrl(o_ctrl),
		.o_addr(o_addr), .o_data_out(o_data_out), .o_data_oe(o_data_oe), .i_data_in(pin));
	dpsw_sram_model dpsw_sram_model_inst (.i_ctrl(o_ctrl), .i_addr(o_addr),
		.i_host_data(o_data_out), .i_host_oe(o_data_oe), .i_other_owns(OTHER),
		.o_pin(pin), .o_clash(clash));
	//----------------------------------------
	// compare, request and closing tasks
	//----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	// wait for idle, present one request for one edge, then wait for done
	task automatic run(input dpsw_cmd_type c, input int a, input int d, input logic [1:0] be);
		int n;
		n = 0;
		while (o_req_ready !== 1'b1 && n < 100) begin
			@(negedge i_clock);
			n++;
		end
		@(posedge i_clock);
		i_req_valid <= 1'b1;
		i_req <= '{c, a[ADDR_WIDTH-1:0], d[DATA_WIDTH-1:0], be};
		@(posedge i_clock);
		i_req_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge i_clock);
			n++;
		end while (o_done !== 1'b1 && n < 100);
		if (n >= 100) err_count++;
	endtask : run
	//----------------------------------------
	// main sequence
	//----------------------------------------
	initial begin
		int a, d;
		logic [1:0] be;
		repeat (6) @(posedge i_clock);
		i_rst <= 1'b0;
		@(negedge i_clock);
		check("ready", o_req_ready, 32'h1);
		check("idle pins", o_ctrl, CTRL_IDLE);
		// random lane writes, each read straight back
		for (int i = 0; i < 24; i++) begin
			a = i % 8;
			d = $random(seed) & 32'hFFFF;
			be = (i < 8) ? 2'h3 : 2'($random(seed));
			run(DPSW_CMD_RAM_WRITE, a, d, be);
			if (be[1]) ref_mem[a][15:8] = d[15:8];
			if (be[0]) ref_mem[a][7:0] = d[7:0];
			run(DPSW_CMD_RAM_READ, a, 0, 2'h3);
			check("ram word", o_rdata, ref_mem[a]);
		end
		$display("ram test done");
		// claim, read and release each flag; far port holds odd ones
		for (int k = 0; k < 8; k++) begin
			for (int v = 0; v < 3; v++) begin
				run(v == 1 ? DPSW_CMD_SEM_READ : DPSW_CMD_SEM_WRITE, k, v >> 1, 2'h3);
				if (v != 1) sem_own[k] = (v == 0) && !OTHER[k];
				check("sem flag", o_rdata, sem_own[k] ? 32'h0 : 32'hFFFF);
				check("sem grant", o_sem_granted, sem_own[k]);
				check("sem agree", o_sem_mismatch, 32'h0);
			end
		end
		$display("semaphore test done");
		check("contention", clash, 32'h0);
		wrap_up();
	end
	// cut a hang short
	initial begin
		repeat (6000) @(posedge i_clock);
		err_count++;
		wrap_up();
	end
endmodule : tb_dpsw_host
bind dpsw_host dpsw_host_checker dpsw_host_checker_inst (.i_clock(i_clock), .i_rst(i_rst),
	.o_done(o_done), .o_ctrl(o_ctrl), .o_addr(o_addr), .o_data_oe(o_data_oe));
`default_nettype wire
